// *** core/uc_fault_pkg.sv ***
package uc_fault_pkg;

  // Command codes of the two registers held by this block.
  localparam logic [7:0] ADDR_UC_ACTION = 8'h4C;
  localparam logic [7:0] ADDR_OT_THRESHOLD = 8'h4F;

  // Reset values.
  localparam logic [7:0] UC_ACTION_RESET = 8'h00;
  localparam logic [15:0] OT_THRESHOLD_RESET = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // Response field codes.
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RUN_THEN_RETRY = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_DISABLE_UNTIL_OK = 2'h3;

  // Retry field codes.
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Timing: the unit times (hold in microseconds, retry in nanoseconds) and the clock rate.
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int HOLD_UNIT_US = 10000;
  localparam int RETRY_UNIT_NS = 8200000;
  localparam int HOLD_UNIT_CYCLES_DEF = (CLK_FREQ_HZ / 1000000) * HOLD_UNIT_US;
  localparam int RETRY_UNIT_CYCLES_DEF = (CLK_FREQ_HZ / 1000000) * (RETRY_UNIT_NS / 1000);
  localparam int UNIT_CNT_W = 18;

  // Field layout of the undercurrent action register, bit 7 first.
  typedef struct packed {
    logic [1:0] response;
    logic [2:0] retries;
    logic [2:0] delay;
  } uc_action_type;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HOLD = 3'b001,
    ST_OFF_WAIT = 3'b010,
    ST_ATTEMPT = 3'b011,
    ST_LATCH_OFF = 3'b100,
    ST_OFF_UNTIL_OK = 3'b101
  } state_type;

endpackage : uc_fault_pkg

// *** core/undercurrent_fault_response.sv ***
`timescale 1ns/10ps
module undercurrent_fault_response
  import uc_fault_pkg::*;
#(
  parameter int HOLD_UNIT_CYCLES = HOLD_UNIT_CYCLES_DEF,
  parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYCLES_DEF
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_UC_FAULT,
  input wire logic I_OUT_CMD_ON,
  input wire logic I_OTHER_SHUTDOWN,
  input wire logic I_FAULT_CLR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  output logic [15:0] O_REG_RDATA,
  output logic O_OUTPUT_EN,
  output logic O_UC_STATUS,
  output logic O_HOST_ALERT_LINE_N
);

  uc_action_type undercurrent_fault_action;
  logic [15:0] overtemp_fault_threshold;
  logic uc_meta;
  logic uc_fault;
  state_type state;
  state_type next_state;
  logic [UNIT_CNT_W-1:0] unit_cnt;
  logic [2:0] units_left;
  logic timer_hold;
  logic timer_done;
  logic timer_load;
  logic timer_clear;
  logic load_hold;
  logic [2:0] attempts;
  logic attempt_inc;
  logic attempt_clr;
  logic abort;
  logic [UNIT_CNT_W-1:0] unit_last;
  logic next_status;
  logic next_output_en;
  logic [15:0] next_rdata;
  logic no_retry;
  logic retry_left;
  logic attempts_full;

  // Register writes; the 8-bit register takes the low byte.
  // Writes to other command codes are dropped without effect.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      undercurrent_fault_action <= UC_ACTION_RESET;
      overtemp_fault_threshold <= OT_THRESHOLD_RESET;
    end else if (I_CE && I_REG_WR) begin
      if (I_REG_ADDR == ADDR_UC_ACTION) begin
        undercurrent_fault_action <= I_REG_WDATA[7:0];
      end
      if (I_REG_ADDR == ADDR_OT_THRESHOLD) begin
        overtemp_fault_threshold <= I_REG_WDATA;
      end
    end
  end

  // Register reads are captured so the data output comes from a flop.
  always_comb begin
    case (I_REG_ADDR)
      ADDR_UC_ACTION: next_rdata = {8'h00, undercurrent_fault_action};
      ADDR_OT_THRESHOLD: next_rdata = overtemp_fault_threshold;
      default: next_rdata = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_REG_RDATA <= READ_UNMAPPED;
    end else if (I_CE && I_REG_RD) begin
      O_REG_RDATA <= next_rdata;
    end
  end

  // The fault comparator is asynchronous to this clock.
  // Only the second flop is read, so logic never sees a metastable level.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      uc_meta <= 1'b0;
      uc_fault <= 1'b0;
    end else if (I_CE) begin
      uc_meta <= I_UC_FAULT;
      uc_fault <= uc_meta;
    end
  end

  // Sticky status; a fault present in the clearing cycle keeps it set.
  always_comb begin
    next_status = uc_fault | (O_UC_STATUS & ~I_FAULT_CLR);
  end

  // Alert is the inverse of the same next value, so the two never disagree.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_UC_STATUS <= 1'b0;
      O_HOST_ALERT_LINE_N <= 1'b1;
    end else if (I_CE) begin
      O_UC_STATUS <= next_status;
      O_HOST_ALERT_LINE_N <= ~next_status;
    end
  end

  // Delay timer: units_left whole units, each of the selected length.
  always_comb begin
    if (timer_hold) begin
      unit_last = UNIT_CNT_W'(HOLD_UNIT_CYCLES - 1);
    end else begin
      unit_last = UNIT_CNT_W'(RETRY_UNIT_CYCLES - 1);
    end
  end

  // Done in the cycle that empties the timer, so attempt starts sit one interval apart.
  always_comb begin
    timer_done = 1'b0;
    if (units_left == 3'h0) begin
      timer_done = 1'b1;
    end else if (units_left == 3'h1 && unit_cnt == unit_last) begin
      timer_done = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      unit_cnt <= '0;
      units_left <= 3'h0;
      timer_hold <= 1'b0;
    end else if (I_CE) begin
      if (timer_clear) begin
        unit_cnt <= '0;
        units_left <= 3'h0;
      end else if (timer_load) begin
        unit_cnt <= '0;
        units_left <= undercurrent_fault_action.delay;
        timer_hold <= load_hold;
      end else if (!timer_done) begin
        if (unit_cnt == unit_last) begin
          unit_cnt <= '0;
          units_left <= units_left - 3'h1;
        end else begin
          unit_cnt <= unit_cnt + UNIT_CNT_W'(1);
        end
      end
    end
  end

  // Attempt counter saturates, so endless retry never wraps into a limit.
  assign attempts_full = (attempts == RETRY_FOREVER);

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      attempts <= 3'h0;
    end else if (I_CE) begin
      if (attempt_clr) begin
        attempts <= 3'h0;
      end else if (attempt_inc && !attempts_full) begin
        attempts <= attempts + 3'h1;
      end
    end
  end

  // Retry field decode shared by the run, hold and off-wait states.
  assign no_retry = (undercurrent_fault_action.retries == RETRY_NONE);
  assign retry_left = (undercurrent_fault_action.retries == RETRY_FOREVER)
                      || (attempts < undercurrent_fault_action.retries);

  // A clear, a command off or another shutdown leaves every retry state.
  always_comb begin
    abort = I_FAULT_CLR | ~I_OUT_CMD_ON | I_OTHER_SHUTDOWN;
  end

  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_clear = 1'b0;
    load_hold = 1'b0;
    attempt_inc = 1'b0;
    attempt_clr = 1'b0;
    if (abort && state != ST_RUN) begin
      next_state = ST_RUN;
      timer_clear = 1'b1;
      attempt_clr = 1'b1;
    end else begin
      case (state)
        ST_RUN: begin
          if (uc_fault && I_OUT_CMD_ON && !I_OTHER_SHUTDOWN) begin
            case (undercurrent_fault_action.response)
              RESP_IGNORE: next_state = ST_RUN;
              RESP_RUN_THEN_RETRY: begin
                next_state = ST_HOLD;
                timer_load = 1'b1;
                load_hold = 1'b1;
              end
              RESP_DISABLE_RETRY: begin
                timer_load = 1'b1;
                attempt_clr = 1'b1;
                if (no_retry) begin
                  next_state = ST_LATCH_OFF;
                end else begin
                  next_state = ST_OFF_WAIT;
                end
              end
              default: next_state = ST_OFF_UNTIL_OK;
            endcase
          end
        end
        ST_HOLD: begin
          if (timer_done) begin
            if (!uc_fault) begin
              next_state = ST_RUN;
            end else if (no_retry) begin
              next_state = ST_LATCH_OFF;
            end else begin
              next_state = ST_OFF_WAIT;
              timer_load = 1'b1;
              attempt_clr = 1'b1;
            end
          end
        end
        ST_OFF_WAIT: begin
          if (timer_done) begin
            if (retry_left) begin
              next_state = ST_ATTEMPT;
              timer_load = 1'b1;
              attempt_inc = 1'b1;
            end else begin
              next_state = ST_LATCH_OFF;
            end
          end
        end
        ST_ATTEMPT: begin
          // A failed attempt keeps the running timer, so starts stay one interval apart.
          if (uc_fault) begin
            next_state = ST_OFF_WAIT;
          end else if (timer_done) begin
            next_state = ST_RUN;
            attempt_clr = 1'b1;
          end
        end
        ST_LATCH_OFF: next_state = ST_LATCH_OFF;
        ST_OFF_UNTIL_OK: begin
          if (!uc_fault) begin
            next_state = ST_RUN;
          end
        end
        default: next_state = ST_RUN;
      endcase
    end
  end

  // The clock enable freezes the machine, timer and counter together mid-wait.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state <= ST_RUN;
    end else if (I_CE) begin
      state <= next_state;
    end
  end

  // The output is on only in the states that keep regulating.
  always_comb begin
    case (next_state)
      ST_RUN: next_output_en = 1'b1;
      ST_HOLD: next_output_en = 1'b1;
      ST_ATTEMPT: next_output_en = 1'b1;
      ST_OFF_WAIT: next_output_en = 1'b0;
      ST_LATCH_OFF: next_output_en = 1'b0;
      ST_OFF_UNTIL_OK: next_output_en = 1'b0;
      default: next_output_en = 1'b0;
    endcase
    if (!I_OUT_CMD_ON || I_OTHER_SHUTDOWN) begin
      next_output_en = 1'b0;
    end
  end

  // Registered from the next state so the enable moves on the same edge as the state.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_OUTPUT_EN <= 1'b0;
    end else if (I_CE) begin
      O_OUTPUT_EN <= next_output_en;
    end
  end

endmodule : undercurrent_fault_response

// *** sim/uc_host_model.sv ***
`timescale 1ns/10ps
module uc_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [15:0] o_wdata = 16'h0000
);
  // A released bus shows the inverse of the last value, so stale data never looks valid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : rd
endmodule : uc_host_model

// *** sim/undercurrent_fault_response_assertions.sv ***
`timescale 1ns/10ps
module uc_fault_assertions
  import uc_fault_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_UC_FAULT,
  input wire logic I_OUT_CMD_ON,
  input wire logic I_OTHER_SHUTDOWN,
  input wire logic I_FAULT_CLR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic [15:0] O_REG_RDATA,
  input wire logic O_OUTPUT_EN,
  input wire logic O_UC_STATUS,
  input wire logic O_HOST_ALERT_LINE_N
);
  logic [7:0] act;
  logic run_ok;
  assign run_ok = I_OUT_CMD_ON && !I_OTHER_SHUTDOWN;
  // Mirror of the action register, frozen with the clock enable like the design.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      act <= UC_ACTION_RESET;
    end else if (I_CE && I_REG_WR && I_REG_ADDR == ADDR_UC_ACTION) begin
      act <= I_REG_WDATA[7:0];
    end
  end
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN);
  a_alert_tracks: assert property (O_HOST_ALERT_LINE_N == !O_UC_STATUS) else $error("alert");
  a_status_set: assert property (I_UC_FAULT [*3] |-> ##[1:2] O_UC_STATUS) else $error("set");
  a_status_sticky: assert property (O_UC_STATUS && !I_FAULT_CLR |=> O_UC_STATUS)
    else $error("sticky");
  a_ignore_runs: assert property ((act[7:6] == RESP_IGNORE && run_ok) [*3] |=> O_OUTPUT_EN)
    else $error("ignore");
  a_disable_fast: assert property ((act[7] && I_UC_FAULT) [*3] |-> ##[0:3] !O_OUTPUT_EN)
    else $error("disable");
  a_resume_ok: assert property
    ((act[7:6] == RESP_DISABLE_UNTIL_OK && !I_UC_FAULT && run_ok) [*5] |=> O_OUTPUT_EN)
    else $error("resume");
  a_latch_held: assert property
    ((act == {RESP_DISABLE_RETRY, RETRY_NONE, act[2:0]} && O_UC_STATUS && !O_OUTPUT_EN
      && run_ok && !I_FAULT_CLR) [*2] |=> !O_OUTPUT_EN) else $error("latch");
  a_read_action: assert property
    (I_REG_RD && I_REG_ADDR == ADDR_UC_ACTION |=> O_REG_RDATA == {8'h00, $past(act)})
    else $error("read");
endmodule : uc_fault_assertions
bind undercurrent_fault_response uc_fault_assertions chk (.*);

// *** sim/test_undercurrent_fault_response.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_undercurrent_fault_response
  import uc_fault_pkg::*;
;
  localparam int HU = 10;
  localparam int RU = 8;
  logic clk, rstn, uc_fault, cmd_on, shut, clr, wr, rd, en, status, alert_n, pe;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v;
  int fail_count = 0;
  int total_checks = 0;
  int m, r, i, t, dl;
  int rises[$];
  integer seed = 32'hB93E;
  integer d;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  undercurrent_fault_response #(.HOLD_UNIT_CYCLES(HU), .RETRY_UNIT_CYCLES(RU)) dut (
    .I_CLK(clk), .I_RSTN(rstn), .I_CE(1'b1), .I_UC_FAULT(uc_fault), .I_OUT_CMD_ON(cmd_on),
    .I_OTHER_SHUTDOWN(shut), .I_FAULT_CLR(clr), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_OUTPUT_EN(en),
    .O_UC_STATUS(status), .O_HOST_ALERT_LINE_N(alert_n));
  uc_host_model host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Turning the output off first aborts any retry state, so a new setting starts clean.
  task automatic restart(input logic [7:0] a);
    @(posedge clk);
    cmd_on <= 1'b0;
    uc_fault <= 1'b0;
    clr <= 1'b1;
    host.wr(ADDR_UC_ACTION, {8'h00, a});
    @(posedge clk);
    clr <= 1'b0;
    cmd_on <= 1'b1;
    tick(4);
  endtask : restart
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    {rstn, uc_fault, cmd_on, shut, clr} = 5'h00;
    tick(6);
    rstn <= 1'b1;
    host.rd(ADDR_UC_ACTION, v);
    `CHK("action reset", {8'h00, UC_ACTION_RESET}, v)
    host.rd(ADDR_OT_THRESHOLD, v);
    `CHK("threshold reset", OT_THRESHOLD_RESET, v)
    d = $random(seed);
    host.wr(ADDR_OT_THRESHOLD, d[15:0]);
    host.wr(ADDR_UC_ACTION, d[31:16]);
    host.wr(8'h4D, ~d[15:0]);
    host.rd(ADDR_OT_THRESHOLD, v);
    `CHK("threshold", d[15:0], v)
    host.rd(ADDR_UC_ACTION, v);
    `CHK("action", {8'h00, d[23:16]}, v)
    host.rd(8'h4D, v);
    `CHK("unmapped", READ_UNMAPPED, v)
    for (m = 0; m < 4; m++) begin
      restart({m[1:0], RETRY_NONE, 3'h2});
      @(posedge clk);
      uc_fault <= 1'b1;
      tick(15);
      `CHK("enable mid", logic'(m < 2), en)
      tick(30);
      `CHK("enable late", logic'(m == 0), en)
      `CHK("status", 1'b1, status)
      `CHK("alert", 1'b0, alert_n)
      @(posedge clk);
      uc_fault <= 1'b0;
      tick(8);
      `CHK("enable after", logic'(m == 0 || m == 3), en)
    end
    for (r = 0; r < 8; r++) begin
      dl = 1 + ($unsigned($random(seed)) % 7);
      restart({RESP_DISABLE_RETRY, r[2:0], dl[2:0]});
      @(posedge clk);
      uc_fault <= 1'b1;
      rises.delete();
      pe = en;
      for (t = 0; t < (r + 2) * dl * RU + 20; t++) begin
        tick(1);
        if (en && !pe) rises.push_back(t);
        pe = en;
      end
      for (i = 1; i < rises.size(); i++) `CHK("spacing", dl * RU, rises[i] - rises[i-1])
      if (r == 7) begin
        `CHK("endless", 1'b1, logic'(rises.size() > 6))
        @(posedge clk);
        shut <= 1'b1;
        tick(2);
        `CHK("shutdown", 1'b0, en)
        @(posedge clk);
        shut <= 1'b0;
      end else begin
        `CHK("attempts", r, rises.size())
        `CHK("latched", 1'b0, en)
      end
      @(posedge clk);
      uc_fault <= 1'b0;
      tick(3);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      tick(4);
      `CHK("cleared", 1'b0, status)
      `CHK("restored", 1'b1, en)
    end
    complete_run();
  end
endmodule : test_undercurrent_fault_response
